/* File: inc/plbas_pkg.sv */
package plbas_pkg;
   localparam logic [3:0]  CMD_MEM_RD   = 4'h6;
   localparam logic [3:0]  CMD_MEM_WR   = 4'h7;
   localparam logic [3:0]  CMD_CFG_RD   = 4'hA;
   localparam logic [3:0]  CMD_CFG_WR   = 4'hB;
   localparam logic [3:0]  CMD_DAC      = 4'hD;
   localparam int          DEVSEL_WAIT  = 5;
   localparam int          MEM_ROWS     = 16;
   localparam int          WIN_LSB      = 7;
   localparam logic [5:0]  CFG_ID_IDX   = 6'h00;
   localparam logic [5:0]  CFG_CMD_IDX  = 6'h01;
   localparam logic [5:0]  CFG_BAR_IDX  = 6'h04;
   localparam int          CMD_MEMEN    = 1;
   // Arbitrary identity value
   localparam logic [31:0] DEV_ID       = 32'h0001_0001;
   localparam logic [15:0] CMD_RST      = 16'h0000;
   localparam logic [31:0] BAR_RST      = 32'h0000_0000;

   typedef enum logic [1:0] {
      T_IDLE  = 2'b00,
      T_CLAIM = 2'b01,
      T_DATA  = 2'b10,
      T_BACK  = 2'b11
   } plbas_tstate_t;

   typedef enum logic [2:0] {
      M_IDLE = 3'b000,
      M_REQ  = 3'b001,
      M_ADDR = 3'b010,
      M_DAC  = 3'b011,
      M_DATA = 3'b100,
      M_TURN = 3'b101
   } plbas_mstate_t;

   function automatic logic par_even(input logic [31:0] ad, input logic [3:0] cbe);
      par_even = ^{ad, cbe};
   endfunction
endpackage

/* File: inc/plbas_bus_if.sv */
interface plbas_bus_if;
   logic [63:0] m_ad, t_ad, ad;
   logic [1:0]  m_ad_oe, t_ad_oe;
   logic [7:0]  m_cbe_n, cbe_n;
   logic        m_cbe_oe;
   logic        m_frame_n, m_irdy_n, m_req64_n, m_ctl_oe;
   logic        t_trdy_n, t_devsel_n, t_ack64_n, t_ctl_oe;
   logic        m_par, m_par_oe, t_par, t_par_oe;
   logic        frame_n, irdy_n, req64_n, trdy_n, devsel_n, ack64_n, par;
   logic        req_n, gnt_n, idsel;

   // Undriven lines float high through the bus pull-ups
   assign ad[31:0]  = m_ad_oe[0] ? m_ad[31:0] : t_ad_oe[0] ? t_ad[31:0] : '1;
   assign ad[63:32] = m_ad_oe[1] ? m_ad[63:32] : t_ad_oe[1] ? t_ad[63:32] : '1;
   assign cbe_n     = m_cbe_oe ? m_cbe_n : '1;
   assign frame_n   = m_ctl_oe ? m_frame_n : 1'b1;
   assign irdy_n    = m_ctl_oe ? m_irdy_n : 1'b1;
   assign req64_n   = m_ctl_oe ? m_req64_n : 1'b1;
   assign trdy_n    = t_ctl_oe ? t_trdy_n : 1'b1;
   assign devsel_n  = t_ctl_oe ? t_devsel_n : 1'b1;
   assign ack64_n   = t_ctl_oe ? t_ack64_n : 1'b1;
   assign par       = m_par_oe ? m_par : t_par_oe ? t_par : 1'b1;

   modport master (
      output m_ad, m_ad_oe, m_cbe_n, m_cbe_oe, m_frame_n, m_irdy_n,
      output m_req64_n, m_ctl_oe, m_par, m_par_oe, req_n,
      input  ad, cbe_n, frame_n, irdy_n, req64_n, trdy_n, devsel_n,
      input  ack64_n, par, gnt_n
   );
   modport target (
      output t_ad, t_ad_oe, t_trdy_n, t_devsel_n, t_ack64_n, t_ctl_oe,
      output t_par, t_par_oe,
      input  ad, cbe_n, frame_n, irdy_n, req64_n, trdy_n, devsel_n,
      input  ack64_n, par, idsel
   );
endinterface

/* File: rtl/plbas_target.sv */
module plbas_target (
   input  wire logic    CLK_I,
   input  wire logic    SRST_I,
   plbas_bus_if.target  BUS,
   output logic         XFER_O,
   output logic         XFER_WR_O,
   output logic         XFER_CFG_O,
   output logic         XFER_WIDE_O,
   output logic [31:0]  XFER_ADDR_O,
   output logic [63:0]  XFER_DATA_O,
   output logic [7:0]   XFER_BE_N_O,
   output logic         MEM_EN_O,
   output logic [31:0]  BAR_O
);
   plbas_pkg::plbas_tstate_t state_ff, nxt_state;
   logic        frame_d_ff;
   logic [31:0] addr_ff, nxt_addr;
   logic        wr_ff, cfg_ff, wide_ff;
   logic [15:0] cmd_ff;
   logic [31:0] bar_ff;
   logic [63:0] ad_ff;
   logic [1:0]  ad_oe_ff;
   logic        devsel_n_ff, trdy_n_ff, ack64_n_ff, ctl_oe_ff;
   logic        par_ff, par_oe_ff;
   logic        addr_ph, cfg_hit, mem_hit, xfer;
   logic [3:0]  cmd;
   logic [7:0]  lane_rd [8];
   logic [63:0] row_rd;

   function automatic logic [31:0] cfg_rd(input logic [5:0] idx,
                                          input logic [15:0] c,
                                          input logic [31:0] b);
      if (idx == plbas_pkg::CFG_ID_IDX)
         cfg_rd = plbas_pkg::DEV_ID;
      else if (idx == plbas_pkg::CFG_CMD_IDX)
         cfg_rd = {16'h0000, c};
      else if (idx == plbas_pkg::CFG_BAR_IDX)
         cfg_rd = b;
      else
         cfg_rd = 32'h0000_0000;
   endfunction

   assign cmd     = BUS.cbe_n[3:0];
   // First low sample of frame marks the address phase
   assign addr_ph = frame_d_ff && !BUS.frame_n;
   assign cfg_hit = BUS.idsel && BUS.ad[1:0] == 2'b00 &&
                    (cmd == plbas_pkg::CMD_CFG_RD || cmd == plbas_pkg::CMD_CFG_WR);
   // Window is single-address only; dual-address cycles pass unclaimed
   assign mem_hit = cmd_ff[plbas_pkg::CMD_MEMEN] &&
                    BUS.ad[31:plbas_pkg::WIN_LSB] == bar_ff[31:plbas_pkg::WIN_LSB] &&
                    (cmd == plbas_pkg::CMD_MEM_RD || cmd == plbas_pkg::CMD_MEM_WR);
   assign xfer    = state_ff == plbas_pkg::T_DATA && !BUS.irdy_n && !BUS.trdy_n;

   always_comb begin
      nxt_addr = addr_ff;
      if (xfer)
         nxt_addr = addr_ff + (wide_ff ? 32'h0000_0008 : 32'h0000_0004);
   end

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         plbas_pkg::T_IDLE: begin
            if (addr_ph && (cfg_hit || mem_hit))
               nxt_state = plbas_pkg::T_CLAIM;
         end
         plbas_pkg::T_CLAIM: begin
            nxt_state = plbas_pkg::T_DATA;
         end
         plbas_pkg::T_DATA: begin
            if (xfer && BUS.frame_n)
               nxt_state = plbas_pkg::T_BACK;
         end
         plbas_pkg::T_BACK: begin
            nxt_state = plbas_pkg::T_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         state_ff   <= plbas_pkg::T_IDLE;
         frame_d_ff <= 1'b1;
      end else begin
         state_ff   <= nxt_state;
         frame_d_ff <= BUS.frame_n;
      end
   end

   // Access attributes captured in the address phase
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         addr_ff <= 32'h0000_0000;
         wr_ff   <= 1'b0;
         cfg_ff  <= 1'b0;
         wide_ff <= 1'b0;
      end else if (state_ff == plbas_pkg::T_IDLE && addr_ph) begin
         addr_ff <= BUS.ad[31:0];
         wr_ff   <= cmd[0];
         cfg_ff  <= cfg_hit;
         wide_ff <= mem_hit && !cfg_hit && !BUS.req64_n;
      end else begin
         addr_ff <= nxt_addr;
      end
   end

   // Handshake outputs; released only after one cycle driven high
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         devsel_n_ff <= 1'b1;
         trdy_n_ff   <= 1'b1;
         ack64_n_ff  <= 1'b1;
         ctl_oe_ff   <= 1'b0;
      end else begin
         devsel_n_ff <= !(nxt_state == plbas_pkg::T_CLAIM ||
                          nxt_state == plbas_pkg::T_DATA);
         trdy_n_ff   <= nxt_state != plbas_pkg::T_DATA;
         ack64_n_ff  <= !((nxt_state == plbas_pkg::T_CLAIM ||
                           nxt_state == plbas_pkg::T_DATA) &&
                          (state_ff == plbas_pkg::T_IDLE ?
                           mem_hit && !cfg_hit && !BUS.req64_n : wide_ff));
         ctl_oe_ff   <= nxt_state != plbas_pkg::T_IDLE;
      end
   end

   // Configuration space
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         cmd_ff <= plbas_pkg::CMD_RST;
         bar_ff <= plbas_pkg::BAR_RST;
      end else if (xfer && cfg_ff && wr_ff) begin
         if (addr_ff[7:2] == plbas_pkg::CFG_CMD_IDX) begin
            if (!BUS.cbe_n[0])
               cmd_ff[7:0] <= BUS.ad[7:0];
            if (!BUS.cbe_n[1])
               cmd_ff[15:8] <= BUS.ad[15:8];
         end
         if (addr_ff[7:2] == plbas_pkg::CFG_BAR_IDX)
            bar_ff <= {BUS.ad[31:plbas_pkg::WIN_LSB], {plbas_pkg::WIN_LSB{1'b0}}};
      end
   end

   // One byte-wide store per lane keeps every lane single-driven
   genvar b;
   generate
      for (b = 0; b < 8; b++) begin : g_lane
         logic [7:0] mem [plbas_pkg::MEM_ROWS];
         logic       we;
         logic [7:0] wd;
         // Narrow beats use lower lanes, steered by address bit 2
         assign we = xfer && wr_ff && !cfg_ff &&
                     (wide_ff ? !BUS.cbe_n[b] :
                      !BUS.cbe_n[b % 4] && addr_ff[2] == 1'(b / 4));
         assign wd = wide_ff ? BUS.ad[8*b +: 8] : BUS.ad[8*(b % 4) +: 8];
         assign lane_rd[b] = mem[nxt_addr[6:3]];
         always_ff @(posedge CLK_I) begin
            if (we)
               mem[addr_ff[6:3]] <= wd;
         end
      end
   endgenerate

   always_comb begin
      for (int i = 0; i < 8; i++)
         row_rd[8*i +: 8] = lane_rd[i];
   end

   // Read word prepared a cycle ahead of its data phase
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         ad_ff    <= 64'h0000_0000_0000_0000;
         ad_oe_ff <= 2'b00;
      end else begin
         if (cfg_ff)
            ad_ff <= {32'h0000_0000, cfg_rd(nxt_addr[7:2], cmd_ff, bar_ff)};
         else if (wide_ff)
            ad_ff <= row_rd;
         else
            ad_ff <= {32'h0000_0000, nxt_addr[2] ? row_rd[63:32] : row_rd[31:0]};
         ad_oe_ff[0] <= nxt_state == plbas_pkg::T_DATA && !wr_ff;
         ad_oe_ff[1] <= nxt_state == plbas_pkg::T_DATA && !wr_ff && wide_ff;
      end
   end

   // Parity follows each driven read word by one cycle
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         par_ff    <= 1'b0;
         par_oe_ff <= 1'b0;
      end else begin
         par_ff    <= plbas_pkg::par_even(ad_ff[31:0], BUS.cbe_n[3:0]);
         par_oe_ff <= ad_oe_ff[0];
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         XFER_O      <= 1'b0;
         XFER_WR_O   <= 1'b0;
         XFER_CFG_O  <= 1'b0;
         XFER_WIDE_O <= 1'b0;
         XFER_ADDR_O <= 32'h0000_0000;
         XFER_DATA_O <= 64'h0000_0000_0000_0000;
         XFER_BE_N_O <= 8'hFF;
      end else begin
         XFER_O <= xfer;
         if (xfer) begin
            XFER_WR_O   <= wr_ff;
            XFER_CFG_O  <= cfg_ff;
            XFER_WIDE_O <= wide_ff;
            XFER_ADDR_O <= addr_ff;
            XFER_DATA_O <= wide_ff ? BUS.ad : {32'h0000_0000, BUS.ad[31:0]};
            XFER_BE_N_O <= wide_ff ? BUS.cbe_n : {4'hF, BUS.cbe_n[3:0]};
         end
      end
   end

   assign MEM_EN_O       = cmd_ff[plbas_pkg::CMD_MEMEN];
   assign BAR_O          = bar_ff;
   assign BUS.t_ad       = ad_ff;
   assign BUS.t_ad_oe    = ad_oe_ff;
   assign BUS.t_devsel_n = devsel_n_ff;
   assign BUS.t_trdy_n   = trdy_n_ff;
   assign BUS.t_ack64_n  = ack64_n_ff;
   assign BUS.t_ctl_oe   = ctl_oe_ff;
   assign BUS.t_par      = par_ff;
   assign BUS.t_par_oe   = par_oe_ff;
endmodule

/* File: rtl/plbas_master.sv */
module plbas_master (
   input  wire logic    CLK_I,
   input  wire logic    SRST_I,
   plbas_bus_if.master  BUS,
   input  wire logic    START_I,
   input  wire logic [3:0]  CMD_I,
   input  wire logic [63:0] ADDR_I,
   input  wire logic    WIDE_I,
   input  wire logic [3:0]  BEATS_I,
   input  wire logic [7:0]  BE_N_I,
   input  wire logic [63:0] WDATA_I,
   output logic         WREADY_O,
   output logic         BUSY_O,
   output logic [63:0]  RDATA_O,
   output logic         RVALID_O,
   output logic         RWIDE_O,
   output logic         DONE_O,
   output logic         ABORT_O
);
   plbas_pkg::plbas_mstate_t state_ff, nxt_state;
   logic [3:0]  cmd_ff;
   logic [63:0] addr_ff;
   logic        wide_ff;
   logic [3:0]  left_ff;
   logic [7:0]  be_n_ff;
   logic [63:0] wdata_ff;
   logic [3:0]  wait_ff;
   logic        claimed_ff;
   logic [63:0] ad_ff;
   logic [1:0]  ad_oe_ff;
   logic [7:0]  cbe_n_ff;
   logic        cbe_oe_ff;
   logic        frame_n_ff, irdy_n_ff, req64_n_ff, ctl_oe_ff;
   logic        par_ff, par_oe_ff, req_n_ff;
   logic        busy_ff, rvalid_ff, rwide_ff, done_ff, abort_ff;
   logic [63:0] rdata_ff;
   logic        is_wr, dac, dac_wide, grant, xfer, timeout, end_ok, end_abort;

   assign is_wr     = cmd_ff[0];
   assign dac       = addr_ff[63:32] != 32'h0000_0000;
   // High half only goes out with the wide request
   assign dac_wide  = dac && wide_ff;
   assign grant     = !BUS.gnt_n && BUS.frame_n && BUS.irdy_n;
   assign xfer      = state_ff == plbas_pkg::M_DATA && !BUS.irdy_n && !BUS.trdy_n;
   assign timeout   = state_ff == plbas_pkg::M_DATA && !claimed_ff && BUS.devsel_n &&
                      wait_ff >= 4'(plbas_pkg::DEVSEL_WAIT);
   assign end_ok    = xfer && BUS.frame_n;
   assign end_abort = timeout && BUS.frame_n && !xfer;
   assign WREADY_O  = xfer && is_wr;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         plbas_pkg::M_IDLE: begin
            if (START_I)
               nxt_state = plbas_pkg::M_REQ;
         end
         plbas_pkg::M_REQ: begin
            if (grant)
               nxt_state = plbas_pkg::M_ADDR;
         end
         plbas_pkg::M_ADDR: begin
            nxt_state = dac ? plbas_pkg::M_DAC : plbas_pkg::M_DATA;
         end
         plbas_pkg::M_DAC: begin
            nxt_state = plbas_pkg::M_DATA;
         end
         plbas_pkg::M_DATA: begin
            if (end_ok || end_abort)
               nxt_state = plbas_pkg::M_TURN;
         end
         plbas_pkg::M_TURN: begin
            nxt_state = plbas_pkg::M_IDLE;
         end
         default: begin
            nxt_state = plbas_pkg::M_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I)
         state_ff <= plbas_pkg::M_IDLE;
      else
         state_ff <= nxt_state;
   end

   // Request captured once; write data after the first beat comes live
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         cmd_ff   <= 4'h0;
         addr_ff  <= 64'h0000_0000_0000_0000;
         wide_ff  <= 1'b0;
         be_n_ff  <= 8'hFF;
         wdata_ff <= 64'h0000_0000_0000_0000;
         left_ff  <= 4'h0;
      end else if (state_ff == plbas_pkg::M_IDLE && START_I) begin
         cmd_ff   <= CMD_I;
         addr_ff  <= ADDR_I;
         wide_ff  <= WIDE_I;
         be_n_ff  <= BE_N_I;
         wdata_ff <= WDATA_I;
         left_ff  <= BEATS_I == 4'h0 ? 4'h1 : BEATS_I;
      end else if (xfer) begin
         left_ff <= left_ff - 4'h1;
      end
   end

   // Unclaimed access gives up after a fixed wait
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         wait_ff    <= 4'h0;
         claimed_ff <= 1'b0;
      end else if (nxt_state == plbas_pkg::M_ADDR) begin
         wait_ff    <= 4'h0;
         claimed_ff <= 1'b0;
      end else begin
         if (!BUS.devsel_n)
            claimed_ff <= 1'b1;
         if ((state_ff == plbas_pkg::M_DAC || state_ff == plbas_pkg::M_DATA) &&
             BUS.devsel_n && wait_ff < 4'hF)
            wait_ff <= wait_ff + 4'h1;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         frame_n_ff <= 1'b1;
         irdy_n_ff  <= 1'b1;
         req64_n_ff <= 1'b1;
         ctl_oe_ff  <= 1'b0;
         ad_ff      <= 64'h0000_0000_0000_0000;
         ad_oe_ff   <= 2'b00;
         cbe_n_ff   <= 8'hFF;
         cbe_oe_ff  <= 1'b0;
         req_n_ff   <= 1'b1;
      end else begin
         req_n_ff <= nxt_state != plbas_pkg::M_REQ;
         unique case (nxt_state)
            plbas_pkg::M_ADDR: begin
               frame_n_ff <= 1'b0;
               req64_n_ff <= !wide_ff;
               ctl_oe_ff  <= 1'b1;
               ad_ff      <= addr_ff;
               ad_oe_ff   <= {dac_wide, 1'b1};
               cbe_n_ff   <= dac ? {dac_wide ? cmd_ff : 4'hF, plbas_pkg::CMD_DAC} :
                                   {4'hF, cmd_ff};
               cbe_oe_ff  <= 1'b1;
            end
            plbas_pkg::M_DAC: begin
               ad_ff[31:0]   <= addr_ff[63:32];
               cbe_n_ff[3:0] <= cmd_ff;
            end
            plbas_pkg::M_DATA: begin
               if (state_ff != plbas_pkg::M_DATA) begin
                  frame_n_ff <= left_ff <= 4'h1;
                  req64_n_ff <= left_ff <= 4'h1 || !wide_ff;
                  irdy_n_ff  <= 1'b0;
                  ad_ff      <= wdata_ff;
                  ad_oe_ff   <= {is_wr && wide_ff, is_wr};
                  cbe_n_ff   <= wide_ff ? be_n_ff : {4'hF, be_n_ff[3:0]};
               end else if (xfer) begin
                  frame_n_ff <= left_ff <= 4'h2;
                  req64_n_ff <= left_ff <= 4'h2 || !wide_ff;
                  ad_ff      <= WDATA_I;
               end else if (timeout) begin
                  // Frame first, ready a cycle later, so the end stays legal
                  frame_n_ff <= 1'b1;
                  req64_n_ff <= 1'b1;
               end
            end
            plbas_pkg::M_TURN: begin
               frame_n_ff <= 1'b1;
               irdy_n_ff  <= 1'b1;
               req64_n_ff <= 1'b1;
               ad_oe_ff   <= 2'b00;
               cbe_oe_ff  <= 1'b0;
            end
            default: begin
               frame_n_ff <= 1'b1;
               irdy_n_ff  <= 1'b1;
               req64_n_ff <= 1'b1;
               ctl_oe_ff  <= 1'b0;
               ad_oe_ff   <= 2'b00;
               cbe_oe_ff  <= 1'b0;
            end
         endcase
      end
   end

   // Parity trails each word this end drove by one cycle
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         par_ff    <= 1'b0;
         par_oe_ff <= 1'b0;
      end else begin
         par_ff    <= plbas_pkg::par_even(ad_ff[31:0], cbe_n_ff[3:0]);
         par_oe_ff <= ad_oe_ff[0];
      end
   end

   // Wide writes assume the target acknowledges the wide path
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         busy_ff   <= 1'b0;
         rvalid_ff <= 1'b0;
         rwide_ff  <= 1'b0;
         rdata_ff  <= 64'h0000_0000_0000_0000;
         done_ff   <= 1'b0;
         abort_ff  <= 1'b0;
      end else begin
         busy_ff   <= nxt_state != plbas_pkg::M_IDLE;
         rvalid_ff <= xfer && !is_wr;
         done_ff   <= end_ok;
         abort_ff  <= end_abort;
         if (xfer && !is_wr) begin
            rwide_ff <= !BUS.ack64_n;
            rdata_ff <= !BUS.ack64_n ? BUS.ad : {32'h0000_0000, BUS.ad[31:0]};
         end
      end
   end

   assign BUSY_O        = busy_ff;
   assign RDATA_O       = rdata_ff;
   assign RVALID_O      = rvalid_ff;
   assign RWIDE_O       = rwide_ff;
   assign DONE_O        = done_ff;
   assign ABORT_O       = abort_ff;
   assign BUS.m_ad      = ad_ff;
   assign BUS.m_ad_oe   = ad_oe_ff;
   assign BUS.m_cbe_n   = cbe_n_ff;
   assign BUS.m_cbe_oe  = cbe_oe_ff;
   assign BUS.m_frame_n = frame_n_ff;
   assign BUS.m_irdy_n  = irdy_n_ff;
   assign BUS.m_req64_n = req64_n_ff;
   assign BUS.m_ctl_oe  = ctl_oe_ff;
   assign BUS.m_par     = par_ff;
   assign BUS.m_par_oe  = par_oe_ff;
   assign BUS.req_n     = req_n_ff;
endmodule

/* File: dv/plbas_sva.sv */
module plbas_sva (
   input logic        CLK_I,
   input logic        SRST_I,
   input logic [63:0] ad,
   input logic [7:0]  cbe_n,
   input logic        frame_n,
   input logic        irdy_n,
   input logic        req64_n,
   input logic        trdy_n,
   input logic        devsel_n,
   input logic        ack64_n,
   input logic        par,
   input logic        idsel
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (SRST_I);
   property p_ack_devsel;
      $fell(ack64_n) |-> $fell(devsel_n);
   endproperty
   a_ack_devsel: assert property (p_ack_devsel) else $error("ack64 not with devsel");
   property p_req_frame;
      $fell(req64_n) |-> $fell(frame_n);
   endproperty
   a_req_frame: assert property (p_req_frame) else $error("req64 not with frame");
   property p_devsel_busy;
      !devsel_n |-> (!frame_n || !irdy_n);
   endproperty
   a_devsel_busy: assert property (p_devsel_busy) else $error("devsel outside access");
   property p_trdy_devsel;
      !trdy_n |-> !devsel_n;
   endproperty
   a_trdy_devsel: assert property (p_trdy_devsel) else $error("trdy without devsel");
   property p_frame_irdy;
      $rose(frame_n) |-> !irdy_n;
   endproperty
   a_frame_irdy: assert property (p_frame_irdy) else $error("frame ended without irdy");
   property p_final;
      frame_n && !irdy_n && !trdy_n |=> irdy_n;
   endproperty
   a_final: assert property (p_final) else $error("irdy held after last word");
   property p_par;
      $fell(frame_n) |=> par == ^{$past(ad[31:0]), $past(cbe_n[3:0])};
   endproperty
   a_par: assert property (p_par) else $error("address parity wrong");
   property p_cfg_idsel;
      $fell(frame_n) && cbe_n[3:1] == 3'h5 && !idsel |-> devsel_n [*6];
   endproperty
   a_cfg_idsel: assert property (p_cfg_idsel) else $error("config claimed unselected");
endmodule

/* File: dv/testbench.sv */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, srst, start, wide, xab;
   logic [3:0]  cmd, beats;
   logic [63:0] addr, wdata, rdata;
   logic [7:0]  be_n;
   logic        xfer, xwr, xcfg, xwide, memen, wrdy, busy, rv, rwide, done, abrt;
   logic [31:0] xaddr, bar;
   logic [63:0] xdata, rd;
   logic [7:0]  xbe_n;
   int          n_errors, comparisons, xcnt, wcnt;
   plbas_bus_if bus();
   plbas_target plbas_target_inst (.CLK_I(clk), .SRST_I(srst), .BUS(bus), .XFER_O(xfer),
      .XFER_WR_O(xwr), .XFER_CFG_O(xcfg), .XFER_WIDE_O(xwide), .XFER_ADDR_O(xaddr),
      .XFER_DATA_O(xdata), .XFER_BE_N_O(xbe_n), .MEM_EN_O(memen), .BAR_O(bar));
   plbas_master plbas_master_inst (.CLK_I(clk), .SRST_I(srst), .BUS(bus), .START_I(start),
      .CMD_I(cmd), .ADDR_I(addr), .WIDE_I(wide), .BEATS_I(beats), .BE_N_I(be_n),
      .WDATA_I(wdata), .WREADY_O(wrdy), .BUSY_O(busy), .RDATA_O(rd), .RVALID_O(rv),
      .RWIDE_O(rwide), .DONE_O(done), .ABORT_O(abrt));
   plbas_sva plbas_sva_inst (.CLK_I(clk), .SRST_I(srst), .ad(bus.ad), .cbe_n(bus.cbe_n),
      .frame_n(bus.frame_n), .irdy_n(bus.irdy_n), .req64_n(bus.req64_n), .trdy_n(bus.trdy_n),
      .devsel_n(bus.devsel_n), .ack64_n(bus.ack64_n), .par(bus.par), .idsel(bus.idsel));
   always #2 clk = ~clk;
   // Lone master: grant follows request a cycle later
   always @(posedge clk) bus.gnt_n <= bus.req_n;
   // Read data kept from the last valid beat only
   always @(posedge clk) begin
      if (xfer === 1'b1) xcnt++;
      if (wrdy === 1'b1) wcnt++;
      if (rv === 1'b1) rdata <= rd;
   end
   task automatic summarize();
      if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", name, exp, got);
      end
   endtask
   // One whole access; the grant tracks the request, so the wait bounds arbitration too
   task automatic xact(input logic [3:0] c, input logic [63:0] a, input logic w,
                       input logic [3:0] b, input logic [7:0] e, input logic [63:0] d);
      int i;
      @(posedge clk);
      start <= 1'h1;
      cmd <= c;
      addr <= a;
      wide <= w;
      beats <= b;
      be_n <= e;
      wdata <= d;
      xab = 1'h0;
      @(posedge clk);
      start <= 1'h0;
      for (i = 0; i < 300 && done !== 1'b1 && abrt !== 1'b1; i++) @(posedge clk);
      if (i == 300) begin
         n_errors++;
         summarize();
      end
      xab = abrt;
      repeat (3) @(posedge clk);
   endtask
   task automatic s_cfg();
      bus.idsel <= 1'h0;
      xact(plbas_pkg::CMD_CFG_WR, 64'h10, 1'h0, 4'h1, 8'hF0, 64'h1000_0000);
      chk("unselected abort", 64'h1, {63'h0, xab});
      chk("bar kept", {32'h0, plbas_pkg::BAR_RST}, {32'h0, bar});
      bus.idsel <= 1'h1;
      xact(plbas_pkg::CMD_CFG_WR, 64'h10, 1'h0, 4'h1, 8'hF0, 64'h1000_0000);
      chk("bar set", 64'h1000_0000, {32'h0, bar});
      xact(plbas_pkg::CMD_CFG_WR, 64'h4, 1'h0, 4'h1, 8'hFC, 64'h2);
      chk("mem enable", 64'h1, {63'h0, memen});
      xact(plbas_pkg::CMD_CFG_RD, 64'h0, 1'h0, 4'h1, 8'hF0, 64'h0);
      chk("id read", {32'h0, plbas_pkg::DEV_ID}, {32'h0, rdata[31:0]});
      bus.idsel <= 1'h0;
   endtask
   task automatic s_mem();
      xcnt = 0;
      wcnt = 0;
      xact(plbas_pkg::CMD_MEM_WR, 64'h1000_0008, 1'h0, 4'h3, 8'hFE, 64'h0);
      chk("narrow beats", 64'h3, 64'(xcnt));
      chk("write ready", 64'h3, 64'(wcnt));
      chk("narrow be", 64'hE, {60'h0, xbe_n[3:0]});
      chk("narrow wide", 64'h0, {63'h0, xwide});
      xact(plbas_pkg::CMD_MEM_WR, 64'h1000_0000, 1'h1, 4'h1, 8'h00, 64'hFEDC_BA98_7654_3210);
      chk("wide flag", 64'h1, {63'h0, xwide});
      chk("wide be", 64'h0, {56'h0, xbe_n});
      chk("wide addr", 64'h1000_0000, {32'h0, xaddr});
      chk("wide data", 64'hFEDC_BA98_7654_3210, xdata);
      xact(plbas_pkg::CMD_MEM_RD, 64'h1000_0000, 1'h1, 4'h1, 8'h00, 64'h0);
      chk("wide read", 64'hFEDC_BA98_7654_3210, rdata);
      chk("read wide", 64'h1, {63'h0, rwide});
      xact(plbas_pkg::CMD_MEM_RD, 64'h1000_0000, 1'h0, 4'h1, 8'hF0, 64'h0);
      chk("narrow read", 64'h7654_3210, {32'h0, rdata[31:0]});
   endtask
   task automatic s_dac();
      xcnt = 0;
      xact(plbas_pkg::CMD_MEM_WR, 64'h1_1000_0000, 1'h1, 4'h1, 8'h00, 64'h0);
      chk("dac abort", 64'h1, {63'h0, xab});
      chk("dac no xfer", 64'h0, 64'(xcnt));
      chk("idle after", 64'h0, {63'h0, busy});
   endtask
   initial begin
      clk = 1'h0;
      srst = 1'h1;
      start = 1'h0;
      cmd = 4'h0;
      addr = 64'h0;
      wide = 1'h0;
      beats = 4'h1;
      be_n = 8'hFF;
      wdata = 64'h0;
      bus.idsel = 1'h0;
      repeat (10) @(posedge clk);
      srst <= 1'h0;
      s_cfg();
      s_mem();
      s_dac();
      summarize();
   end
endmodule
